// >>> dv/sertr_remote.sv
// Behavioural remote transceiver on the two serial lines.
`timescale 1ns/1ps
module sertr_remote (
  // Clock
  input  wire logic hclk,
  // Serial lines
  input  wire logic line_in,
  output      logic line_out
);
  initial line_out = 1'b1;

  // Samples each bit near its middle, so the start edge may be seen half a cycle late.
  task automatic catch_frame(input int bl, nb, output logic [11:0] b);
    int w;
    b = 12'h0;
    for (w = 0; w < 3000 && line_in !== 1'b0; w++) @(negedge hclk);
    if (w == 3000) begin
      b = 12'hxxx;
    end else begin
      repeat (bl / 2) @(negedge hclk);
      for (int i = 0; i < nb; i++) begin
        b[i] = line_in;
        if (i < nb - 1) repeat (bl) @(negedge hclk);
      end
    end
  endtask

  // The last bit sent is a stop bit, so the line is left at the idle high level.
  task automatic send_frame(input int bl, nb, input logic [11:0] b);
    for (int i = 0; i < nb; i++) begin
      @(posedge hclk);
      line_out <= b[i];
      repeat (bl - 1) @(posedge hclk);
    end
  endtask
endmodule

// >>> dv/sertr_top_asserts.sv
// Port checks of the serial transmitter and receiver.
`timescale 1ns/1ps
module sertr_top_asserts (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // Line and interrupt
  input wire logic        serial_out_pin,
  input wire logic        serial_out_oe,
  input wire logic        tx_complete_irq,
  input wire logic        tx_complete_irq_ack
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");
  a_rdata_hold: assert property (
    !$past(hsel && hready && htrans[1] && !hwrite) |-> $stable(hrdata))
    else $error("read data moved without a read");
  a_start_min: assert property (
    serial_out_oe && $fell(serial_out_pin) |-> !serial_out_pin [*8])
    else $error("low bit shorter than eight cycles");
  a_mark_min: assert property (
    serial_out_oe && $rose(serial_out_pin) |-> serial_out_pin [*8])
    else $error("high bit shorter than eight cycles");
  a_enable_idle: assert property ($rose(serial_out_oe) |-> serial_out_pin)
    else $error("line not idle when taken over");
  a_release_idle: assert property ($fell(serial_out_oe) |-> $past(serial_out_pin, 8))
    else $error("pin released inside a frame");
  a_done_stop: assert property (
    $rose(tx_complete_irq) |-> serial_out_pin && $past(serial_out_pin, 8))
    else $error("complete raised before stop bit ended");
  a_ack_clears: assert property (
    tx_complete_irq_ack && tx_complete_irq |-> ##2 !tx_complete_irq)
    else $error("complete request survived service");
endmodule

bind sertr_top sertr_top_asserts sertr_top_asserts_inst (.hclk, .hresetn, .hsel, .htrans,
  .hwrite, .hready, .hreadyout, .hrdata, .hresp, .serial_out_pin, .serial_out_oe,
  .tx_complete_irq, .tx_complete_irq_ack);

// >>> dv/test_sertr_top.sv
// Register-level bench of the serial transmitter and receiver.
`timescale 1ns/1ps
module test_sertr_top;
  import sertr_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        ack = 1'b0;
  logic        xck_in = 1'b0;
  logic [31:0] rd;
  logic [11:0] got;
  wire  [31:0] hrdata;
  wire         rdy, resp, sout, soe, sin, tco, tcoe, irq_e, irq_c;
  int          fails = 0;
  int          n_tests = 0;
  int          k;
  int          tn[6] = '{5, 6, 7, 8, 8, 9};
  logic [5:0]  tp = 6'b011100;
  logic [5:0]  to = 6'b010000;
  logic [8:0]  td[6] = '{9'h0df, 9'h0aa, 9'h013, 9'h0a5, 9'h03c, 9'h15a};

  always #2.5 hclk = ~hclk;

  sertr_top sertr_top_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(rdy), .hreadyout(rdy), .hrdata, .hresp(resp), .serial_in_pin(sin),
    .serial_out_pin(sout), .serial_out_oe(soe), .transfer_clock_in(xck_in),
    .transfer_clock_out(tco), .transfer_clock_oe(tcoe), .tx_empty_irq(irq_e),
    .tx_complete_irq(irq_c), .tx_complete_irq_ack(ack));
  sertr_remote sertr_remote_inst (.hclk, .line_in(sout), .line_out(sin));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    k = 0;
    do @(posedge hclk); while (rdy !== 1'b1 && ++k < 9);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (rdy !== 1'b1 && ++k < 18);
    rd = hrdata;
    if (k > 8) begin
      fails++;
      tally_and_finish();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    check(rd, e);
  endtask

  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    int i;
    for (i = 0; i < 300; i++) begin
      bus(a, 1'b0, 32'h0);
      if ((rd & m) === m) break;
    end
    if (i == 300) begin
      fails++;
      tally_and_finish();
    end
  endtask

  function automatic logic [11:0] fr(input logic [8:0] d, input int n, input logic pe, po);
    logic [11:0] f;
    logic        p;
    f = 12'h0;
    p = po;
    for (int i = 0; i < n; i++) begin
      f[i+1] = d[i];
      p ^= d[i];
    end
    if (pe) f[n+1] = p;
    f[n+1+pe] = 1'b1;
    return f;
  endfunction

  task automatic cfg(input int n, input logic pe, po, s2, input logic [7:0] x);
    logic [2:0] z;
    z = (n == 9) ? 3'h7 : 3'(n - 5);
    wr(OFF_CSC, {26'h0, pe, po, s2, z[1:0], 1'b0});
    wr(OFF_CSB, {24'h0, x | 8'h18 | {5'h0, z[2], 2'h0}});
  endtask

  task automatic frm(input int bl, n, input logic pe, po, input logic [8:0] d);
    sertr_remote_inst.catch_frame(bl, n + 2 + pe, got);
    check({20'h0, got}, {20'h0, fr(d, n, pe, po)});
    if ($isunknown(got)) tally_and_finish();
  endtask

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(OFF_CSA, 32'h20);
    rdc(OFF_CSB, 32'h0);
    rdc(OFF_CSC, 32'h6);
    wr(8'h14, 32'hff);
    rdc(8'h14, 32'h0);
    wr(OFF_BAUD, 32'h0);
    for (int i = 0; i < 6; i++) begin
      cfg(tn[i], tp[i], to[i], 1'b0, {7'h0, td[i][8]});
      // The pin is taken over one cycle after the enable bit lands.
      repeat (2) @(posedge hclk);
      check({31'h0, soe}, 32'h1);
      wr(OFF_DATA, {24'h0, td[i][7:0]});
      frm(16, tn[i], tp[i], to[i], td[i]);
      poll(OFF_CSA, 32'h40);
      wr(OFF_CSA, 32'h40);
      rdc(OFF_CSA, 32'h20);
    end
    wr(OFF_CSA, 32'h2);
    cfg(8, 1'b0, 1'b0, 1'b0, 8'h0);
    wr(OFF_DATA, 32'h81);
    frm(8, 8, 1'b0, 1'b0, 9'h081);
    poll(OFF_CSA, 32'h40);
    wr(OFF_CSA, 32'h40);
    // Synchronous master: four-cycle baud ticks give eight-cycle bits.
    wr(OFF_BAUD, 32'h3);
    wr(OFF_CSC, 32'h46);
    repeat (2) @(posedge hclk);
    check({31'h0, tcoe}, 32'h1);
    wr(OFF_DATA, 32'h5c);
    frm(8, 8, 1'b0, 1'b0, 9'h05c);
    poll(OFF_CSA, 32'h40);
    wr(OFF_CSA, 32'h40);
    // Synchronous slave: each rising edge of the far clock moves one bit.
    wr(OFF_CSC, 32'h47);
    fork
      repeat (26) begin
        repeat (8) @(posedge hclk);
        xck_in <= ~xck_in;
      end
      begin
        wr(OFF_DATA, 32'h3a);
        frm(16, 8, 1'b0, 1'b0, 9'h03a);
      end
    join
    poll(OFF_CSA, 32'h40);
    wr(OFF_CSA, 32'h40);
    wr(OFF_BAUD, 32'h0);
    // Both interrupts enabled; the second word waits in the buffer behind the first.
    cfg(8, 1'b0, 1'b0, 1'b0, 8'h60);
    repeat (2) @(posedge hclk);
    check({31'h0, irq_e}, 32'h1);
    check({30'h0, tcoe, tco}, 32'h0);
    fork
      begin
        frm(16, 8, 1'b0, 1'b0, 9'h011);
        frm(16, 8, 1'b0, 1'b0, 9'h0ee);
      end
      begin
        wr(OFF_DATA, 32'h11);
        poll(OFF_CSA, 32'h20);
        wr(OFF_DATA, 32'hee);
        rdc(OFF_CSA, 32'h0);
        repeat (2) @(posedge hclk);
        check({31'h0, irq_e}, 32'h0);
        wr(OFF_CSB, 32'h58);
      end
    join
    poll(OFF_CSA, 32'h40);
    repeat (2) @(posedge hclk);
    check({31'h0, irq_c}, 32'h1);
    ack <= 1'b1;
    @(posedge hclk);
    ack <= 1'b0;
    rdc(OFF_CSA, 32'h20);
    wr(OFF_DATA, 32'h96);
    wr(OFF_CSB, 32'h10);
    check({31'h0, soe}, 32'h1);
    frm(16, 8, 1'b0, 1'b0, 9'h096);
    for (k = 0; k < 40 && soe !== 1'b0; k++) @(posedge hclk);
    check({31'h0, soe}, 32'h0);
    // Two stop bits configured, yet the far side starts again after one.
    cfg(8, 1'b0, 1'b0, 1'b1, 8'h0);
    fork
      begin
        sertr_remote_inst.send_frame(16, 10, fr(9'h0c3, 8, 1'b0, 1'b0));
        sertr_remote_inst.send_frame(16, 10, fr(9'h05a, 8, 1'b0, 1'b0));
      end
      begin
        poll(OFF_CSA, 32'h80);
        rdc(OFF_DATA, 32'hc3);
        poll(OFF_CSA, 32'h80);
        rdc(OFF_DATA, 32'h5a);
      end
    join
    cfg(5, 1'b0, 1'b0, 1'b0, 8'h0);
    sertr_remote_inst.send_frame(16, 7, fr(9'h015, 5, 1'b0, 1'b0));
    poll(OFF_CSA, 32'h80);
    rdc(OFF_DATA, 32'h15);
    cfg(9, 1'b0, 1'b0, 1'b0, 8'h0);
    sertr_remote_inst.send_frame(16, 11, fr(9'h1a5, 9, 1'b0, 1'b0));
    poll(OFF_CSA, 32'h80);
    rdc(OFF_CSB, 32'h1e);
    rdc(OFF_DATA, 32'ha5);
    tally_and_finish();
  end
endmodule

// >>> verilog/sertr_fmt_if.sv
// Frame format bundle shared by the transmit and receive shifters.
`timescale 1ns/1ps
interface sertr_fmt_if;
  logic [3:0] nbits;
  logic       par_en;
  logic       par_odd;
  logic       two_stop;
  modport src  (output nbits, output par_en, output par_odd, output two_stop);
  modport sink (input nbits, input par_en, input par_odd, input two_stop);
endinterface

// >>> verilog/sertr_pkg.sv
// Shared constants and types of the serial transmitter and receiver.
package sertr_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_CSA  = 8'h04;
  localparam logic [7:0] OFF_CSB  = 8'h08;
  localparam logic [7:0] OFF_CSC  = 8'h0c;
  localparam logic [7:0] OFF_BAUD = 8'h10;

  // ctrl_status_a fields.
  localparam int CSA_RX_FULL  = 7;
  localparam int CSA_TX_DONE  = 6;
  localparam int CSA_TX_EMPTY = 5;
  localparam int CSA_DSPEED   = 1;

  // ctrl_status_b fields.
  localparam int CSB_TXC_IE   = 6;
  localparam int CSB_EMPTY_IE = 5;
  localparam int CSB_RX_EN    = 4;
  localparam int CSB_TX_EN    = 3;
  localparam int CSB_SIZE_HI  = 2;
  localparam int CSB_RX_BIT8  = 1;
  localparam int CSB_TX_BIT8  = 0;

  // Frame control fields.
  localparam int CSC_SYNC     = 6;
  localparam int CSC_PAR_EN   = 5;
  localparam int CSC_PAR_ODD  = 4;
  localparam int CSC_STOP2    = 3;
  localparam int CSC_SIZE_LO  = 1;
  localparam int CSC_EXT_CLK  = 0;

  // Reset values and encodings.
  localparam logic [2:0] CHAR_SIZE_RST = 3'h3;
  localparam logic [2:0] CHAR_SIZE_9   = 3'h7;
  localparam logic [4:0] SPB_NORMAL    = 5'h10;
  localparam logic [4:0] SPB_DOUBLE    = 5'h08;
  localparam int         FRAME_W       = 12;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_START = 3'b010,
    RX_BITS  = 3'b100
  } sertr_rx_state_e;

endpackage

// >>> verilog/sertr_rx.sv
// Receive shifter: start detection, mid-bit sampling, first stop bit.
`timescale 1ns/1ps
module sertr_rx
  import sertr_pkg::*;
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Format and timing
  sertr_fmt_if.sink       fmt,
  input  wire logic       enable,
  input  wire logic       tick,
  input  wire logic [3:0] spb_m1,
  input  wire logic [3:0] half,
  input  wire logic       rxd,
  // Completed character
  output      logic       valid_ff,
  output      logic [8:0] data_ff
);

  sertr_rx_state_e state_ff;
  logic [3:0]      cnt_ff;
  logic [3:0]      idx_ff;
  logic [8:0]      sh_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= RX_IDLE;
      cnt_ff   <= 4'h0;
      idx_ff   <= 4'h0;
      sh_ff    <= 9'h000;
      valid_ff <= 1'b0;
      data_ff  <= 9'h000;
    end else begin
      valid_ff <= 1'b0;
      if (!enable) begin
        state_ff <= RX_IDLE;
      end else if (tick) begin
        case (state_ff)
          RX_IDLE: begin
            if (!rxd) begin
              cnt_ff   <= 4'h0;
              idx_ff   <= 4'h0;
              sh_ff    <= 9'h000;
              // With one sample per bit the low level is the start bit itself.
              state_ff <= (spb_m1 == 4'h0) ? RX_BITS : RX_START;
            end
          end
          RX_START: begin
            if (cnt_ff == half) begin
              cnt_ff   <= 4'h0;
              state_ff <= rxd ? RX_IDLE : RX_BITS;
            end else begin
              cnt_ff <= cnt_ff + 4'h1;
            end
          end
          RX_BITS: begin
            if (cnt_ff == spb_m1) begin
              cnt_ff <= 4'h0;
              idx_ff <= idx_ff + 4'h1;
              if (idx_ff < fmt.nbits) begin
                sh_ff[idx_ff] <= rxd;
              end else if (!(fmt.par_en && idx_ff == fmt.nbits)) begin
                // First stop bit ends the frame; a second one is never awaited.
                valid_ff <= 1'b1;
                data_ff  <= sh_ff;
                state_ff <= RX_IDLE;
              end
            end else begin
              cnt_ff <= cnt_ff + 4'h1;
            end
          end
          default: state_ff <= RX_IDLE;
        endcase
      end
    end
  end

endmodule

// >>> verilog/sertr_top.sv
// Serial transmitter and receiver with its AHB-Lite register slave.
//
// How it works
// - Transmit enable takes output pin, sync clock
// - Data write fills buffer, shifter loads
// - Bits above character length are dropped
// - Buffer-empty flag follows transmit buffer state
// - Empty interrupt requested while empty flag high
// - Complete flag sets when frame done, buffer empty
// - Complete flag clears on service or one
// - Complete interrupt raised when flag sets
// - Parity bit sits after last data bit
// - Disable waits for idle shifter and buffer
// - Receive enable takes input pin, sync clock
// - Valid start bit begins frame, bits sampled
// - Second stop bit ignored by receiver
// - First stop bit moves frame to buffer
// - Unused upper received bits read zero
// - Start low, data LSB first, stops high
// - Parity is XOR of data, inverted odd
// - Odd select chooses parity type when enabled
// - Bit rate divides baud ticks 16, 8, 2
`timescale 1ns/1ps
module sertr_top
  import sertr_pkg::*;
#(
  parameter int DIV_W = 12
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output      logic        hreadyout,
  output      logic [31:0] hrdata,
  output      logic        hresp,
  // Serial pins
  input  wire logic        serial_in_pin,
  output      logic        serial_out_pin,
  output      logic        serial_out_oe,
  input  wire logic        transfer_clock_in,
  output      logic        transfer_clock_out,
  output      logic        transfer_clock_oe,
  // Interrupt requests
  output      logic        tx_empty_irq,
  output      logic        tx_complete_irq,
  input  wire logic        tx_complete_irq_ack
);

  generate
    if (DIV_W < 1 || DIV_W > 16) begin : g_bad_width
      $error("DIV_W must lie between 1 and 16");
    end
  endgenerate

  // Configuration registers.
  logic             double_speed_ff;
  logic             tx_complete_irq_enable_ff;
  logic             tx_empty_irq_enable_ff;
  logic             rx_enable_ff;
  logic             tx_enable_ff;
  logic [2:0]       char_size_ff;
  logic             tx_bit8_ff;
  logic             sync_mode_ff;
  logic             ext_clock_ff;
  logic             parity_enable_ff;
  logic             parity_odd_ff;
  logic             two_stop_ff;
  logic [DIV_W-1:0] baud_divisor_ff;
  // Status and buffers.
  logic [8:0]       tx_buf_ff;
  logic             tx_buf_full_ff;
  logic             tx_complete_ff;
  logic             tx_on_ff;
  logic [8:0]       rx_buf_ff;
  logic             rx_full_ff;
  logic             tx_empty_irq_ff;
  logic             tx_complete_irq_ff;
  // Clocking.
  logic [DIV_W-1:0] baud_cnt_ff;
  logic [3:0]       tx_div_ff;
  logic             xck_ff;
  logic             xck_prev_ff;
  logic             xck_oe_ff;
  // Bus.
  logic [31:0]      hrdata_ff;
  logic             wr_pend_ff;
  logic [7:0]       wr_addr_ff;
  logic             hreadyout_ff;
  logic             hresp_ff;
  // Combinational.
  logic             addr_phase;
  logic             mapped;
  logic [31:0]      rd_val;
  logic             wr_data;
  logic             wr_csa;
  logic             wr_csb;
  logic             wr_csc;
  logic             wr_baud;
  logic             rd_data;
  logic             baud_tick;
  logic [3:0]       spb_m1;
  logic             tx_bit_en;
  logic             rx_tick;
  logic [3:0]       rx_m1;
  logic             tx_take;
  logic             tx_busy;
  logic             tx_done;
  logic             tx_line;
  logic             rx_valid;
  logic [8:0]       rx_word;

  sertr_fmt_if fmt ();

  always_comb begin
    case (char_size_ff)
      3'h0:        fmt.nbits = 4'h5;
      3'h1:        fmt.nbits = 4'h6;
      3'h2:        fmt.nbits = 4'h7;
      CHAR_SIZE_9: fmt.nbits = 4'h9;
      default:     fmt.nbits = 4'h8;
    endcase
  end
  assign fmt.par_en   = parity_enable_ff;
  assign fmt.par_odd  = parity_odd_ff;
  assign fmt.two_stop = two_stop_ff;

  // Bus slave: zero wait states, read data registered in the address phase.
  assign addr_phase = hsel && hready && htrans[1];
  assign mapped     = (haddr[31:8] == 24'h000000);
  assign wr_data    = wr_pend_ff && (wr_addr_ff == OFF_DATA);
  assign wr_csa     = wr_pend_ff && (wr_addr_ff == OFF_CSA);
  assign wr_csb     = wr_pend_ff && (wr_addr_ff == OFF_CSB);
  assign wr_csc     = wr_pend_ff && (wr_addr_ff == OFF_CSC);
  assign wr_baud    = wr_pend_ff && (wr_addr_ff == OFF_BAUD);
  assign rd_data    = addr_phase && !hwrite && mapped && (haddr[7:0] == OFF_DATA);

  always_comb begin
    rd_val = 32'h00000000;
    if (mapped) begin
      case (haddr[7:0])
        OFF_DATA: rd_val[7:0] = rx_buf_ff[7:0];
        OFF_CSA: begin
          rd_val[CSA_RX_FULL]  = rx_full_ff;
          rd_val[CSA_TX_DONE]  = tx_complete_ff;
          rd_val[CSA_TX_EMPTY] = !tx_buf_full_ff;
          rd_val[CSA_DSPEED]   = double_speed_ff;
        end
        OFF_CSB: begin
          rd_val[CSB_TXC_IE]   = tx_complete_irq_enable_ff;
          rd_val[CSB_EMPTY_IE] = tx_empty_irq_enable_ff;
          rd_val[CSB_RX_EN]    = rx_enable_ff;
          rd_val[CSB_TX_EN]    = tx_enable_ff;
          rd_val[CSB_SIZE_HI]  = char_size_ff[2];
          rd_val[CSB_RX_BIT8]  = rx_buf_ff[8];
          rd_val[CSB_TX_BIT8]  = tx_bit8_ff;
        end
        OFF_CSC: begin
          rd_val[CSC_SYNC]                  = sync_mode_ff;
          rd_val[CSC_PAR_EN]                = parity_enable_ff;
          rd_val[CSC_PAR_ODD]               = parity_odd_ff;
          rd_val[CSC_STOP2]                 = two_stop_ff;
          rd_val[CSC_SIZE_LO+1:CSC_SIZE_LO] = char_size_ff[1:0];
          rd_val[CSC_EXT_CLK]               = ext_clock_ff;
        end
        OFF_BAUD: rd_val[DIV_W-1:0] = baud_divisor_ff;
        default:  rd_val = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff    <= 32'h00000000;
      wr_pend_ff   <= 1'b0;
      wr_addr_ff   <= 8'h00;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else begin
      wr_pend_ff <= addr_phase && hwrite && mapped;
      if (addr_phase) begin
        wr_addr_ff <= haddr[7:0];
        if (!hwrite) begin
          hrdata_ff <= rd_val;
        end
      end
    end
  end

  // Configuration; the tx_buffer_empty position is read-only, so writing zero is harmless.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      double_speed_ff           <= 1'b0;
      tx_complete_irq_enable_ff <= 1'b0;
      tx_empty_irq_enable_ff    <= 1'b0;
      rx_enable_ff              <= 1'b0;
      tx_enable_ff              <= 1'b0;
      char_size_ff              <= CHAR_SIZE_RST;
      tx_bit8_ff                <= 1'b0;
      sync_mode_ff              <= 1'b0;
      ext_clock_ff              <= 1'b0;
      parity_enable_ff          <= 1'b0;
      parity_odd_ff             <= 1'b0;
      two_stop_ff               <= 1'b0;
      baud_divisor_ff           <= '0;
    end else begin
      if (wr_csa) begin
        double_speed_ff <= hwdata[CSA_DSPEED];
      end
      if (wr_csb) begin
        tx_complete_irq_enable_ff <= hwdata[CSB_TXC_IE];
        tx_empty_irq_enable_ff    <= hwdata[CSB_EMPTY_IE];
        rx_enable_ff              <= hwdata[CSB_RX_EN];
        tx_enable_ff              <= hwdata[CSB_TX_EN];
        char_size_ff[2]           <= hwdata[CSB_SIZE_HI];
        tx_bit8_ff                <= hwdata[CSB_TX_BIT8];
      end
      if (wr_csc) begin
        sync_mode_ff      <= hwdata[CSC_SYNC];
        parity_enable_ff  <= hwdata[CSC_PAR_EN];
        parity_odd_ff     <= hwdata[CSC_PAR_ODD];
        two_stop_ff       <= hwdata[CSC_STOP2];
        char_size_ff[1:0] <= hwdata[CSC_SIZE_LO+1:CSC_SIZE_LO];
        ext_clock_ff      <= hwdata[CSC_EXT_CLK];
      end
      if (wr_baud) begin
        baud_divisor_ff <= hwdata[DIV_W-1:0];
      end
    end
  end

  // Baud generator and bit timing.
  assign baud_tick = (baud_cnt_ff == '0);
  assign spb_m1    = double_speed_ff ? 4'(SPB_DOUBLE - 5'h01) : 4'(SPB_NORMAL - 5'h01);

  always_comb begin
    if (sync_mode_ff && ext_clock_ff) begin
      tx_bit_en = transfer_clock_in && !xck_prev_ff;
      rx_tick   = !transfer_clock_in && xck_prev_ff;
      rx_m1     = 4'h0;
    end else if (sync_mode_ff) begin
      // The driven clock toggles per baud tick, so a bit spans two ticks.
      tx_bit_en = baud_tick && !xck_ff;
      rx_tick   = baud_tick && xck_ff;
      rx_m1     = 4'h0;
    end else begin
      tx_bit_en = baud_tick && (tx_div_ff == spb_m1);
      rx_tick   = baud_tick;
      rx_m1     = spb_m1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_cnt_ff <= '0;
      tx_div_ff   <= 4'h0;
      xck_ff      <= 1'b0;
      xck_prev_ff <= 1'b0;
      xck_oe_ff   <= 1'b0;
    end else begin
      xck_prev_ff <= transfer_clock_in;
      xck_oe_ff   <= sync_mode_ff && !ext_clock_ff && (tx_on_ff || rx_enable_ff);
      if (wr_baud) begin
        baud_cnt_ff <= hwdata[DIV_W-1:0];
      end else if (baud_tick) begin
        baud_cnt_ff <= baud_divisor_ff;
      end else begin
        baud_cnt_ff <= baud_cnt_ff - 1'b1;
      end
      if (baud_tick) begin
        tx_div_ff <= (tx_div_ff >= spb_m1) ? 4'h0 : tx_div_ff + 4'h1;
        xck_ff    <= sync_mode_ff ? !xck_ff : 1'b0;
      end
    end
  end

  sertr_tx sertr_tx_inst (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .fmt       (fmt),
    .bit_en    (tx_bit_en && tx_on_ff),
    .buf_valid (tx_buf_full_ff),
    .buf_data  (tx_buf_ff),
    .take      (tx_take),
    .busy_ff   (tx_busy),
    .done_ff   (tx_done),
    .txd_ff    (tx_line)
  );

  sertr_rx sertr_rx_inst (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .fmt      (fmt),
    .enable   (rx_enable_ff),
    .tick     (rx_tick),
    .spb_m1   (rx_m1),
    .half     (spb_m1 >> 1),
    .rxd      (serial_in_pin),
    .valid_ff (rx_valid),
    .data_ff  (rx_word)
  );

  // Transmit buffer, flags and enable; a data write wins over a same-cycle take.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_buf_ff      <= 9'h000;
      tx_buf_full_ff <= 1'b0;
      tx_complete_ff <= 1'b0;
      tx_on_ff       <= 1'b0;
    end else begin
      if (wr_data) begin
        tx_buf_ff      <= {tx_bit8_ff, hwdata[7:0]};
        tx_buf_full_ff <= 1'b1;
      end else if (tx_take) begin
        tx_buf_full_ff <= 1'b0;
      end
      if (tx_done) begin
        tx_complete_ff <= 1'b1;
      end else if (tx_complete_irq_ack || (wr_csa && hwdata[CSA_TX_DONE])) begin
        tx_complete_ff <= 1'b0;
      end
      if (tx_enable_ff) begin
        tx_on_ff <= 1'b1;
      end else if (!tx_busy && !tx_buf_full_ff) begin
        tx_on_ff <= 1'b0;
      end
    end
  end

  // Receive buffer and interrupt requests; a new character wins over a read.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_buf_ff          <= 9'h000;
      rx_full_ff         <= 1'b0;
      tx_empty_irq_ff    <= 1'b0;
      tx_complete_irq_ff <= 1'b0;
    end else begin
      if (rx_valid) begin
        rx_buf_ff  <= rx_word;
        rx_full_ff <= 1'b1;
      end else if (rd_data) begin
        rx_full_ff <= 1'b0;
      end
      tx_empty_irq_ff    <= tx_empty_irq_enable_ff && !tx_buf_full_ff;
      tx_complete_irq_ff <= tx_complete_irq_enable_ff && tx_complete_ff;
    end
  end

  assign hreadyout          = hreadyout_ff;
  assign hrdata             = hrdata_ff;
  assign hresp              = hresp_ff;
  assign serial_out_pin     = tx_line;
  assign serial_out_oe      = tx_on_ff;
  assign transfer_clock_out = xck_ff;
  assign transfer_clock_oe  = xck_oe_ff;
  assign tx_empty_irq       = tx_empty_irq_ff;
  assign tx_complete_irq    = tx_complete_irq_ff;

endmodule

// >>> verilog/sertr_tx.sv
// Transmit shift register with frame builder and parity generator.
`timescale 1ns/1ps
module sertr_tx
  import sertr_pkg::*;
(
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Format
  sertr_fmt_if.sink       fmt,
  // Bit timing and buffer
  input  wire logic       bit_en,
  input  wire logic       buf_valid,
  input  wire logic [8:0] buf_data,
  output      logic       take,
  // Status and line
  output      logic       busy_ff,
  output      logic       done_ff,
  output      logic       txd_ff
);

  logic [3:0]         cnt_ff;
  logic [FRAME_W-1:0] shift_ff;
  logic [3:0]         total;

  // Data bits beyond the character length never reach the line.
  function automatic logic [FRAME_W-1:0] build(input logic [8:0] d, input logic [3:0] nb,
                                               input logic pe, input logic po);
    logic [FRAME_W-1:0] f;
    logic               p;
    f = '1;
    p = po;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(nb)) begin
        f[i] = d[i];
        p    = p ^ d[i];
      end
    end
    if (pe) begin
      f[nb] = p;
    end
    return f;
  endfunction

  assign total = fmt.nbits + {3'h0, fmt.par_en} + {3'h0, fmt.two_stop} + 4'h1;
  assign take  = bit_en && (cnt_ff == 4'h0) && buf_valid;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff   <= 4'h0;
      shift_ff <= '1;
      busy_ff  <= 1'b0;
      done_ff  <= 1'b0;
      txd_ff   <= 1'b1;
    end else begin
      done_ff <= 1'b0;
      if (bit_en) begin
        if (cnt_ff != 4'h0) begin
          txd_ff   <= shift_ff[0];
          shift_ff <= {1'b1, shift_ff[FRAME_W-1:1]};
          cnt_ff   <= cnt_ff - 4'h1;
        end else if (buf_valid) begin
          // A waiting word starts right behind the last stop bit.
          txd_ff   <= 1'b0;
          shift_ff <= build(buf_data, fmt.nbits, fmt.par_en, fmt.par_odd);
          cnt_ff   <= total;
          busy_ff  <= 1'b1;
        end else begin
          txd_ff  <= 1'b1;
          done_ff <= busy_ff;
          busy_ff <= 1'b0;
        end
      end
    end
  end

endmodule
